// [shared/cipr_pkg.sv]
// constants for the input, pll and bias configuration register slice
// assumes a 7-bit register address and 9-bit register data
package cipr_pkg;

  localparam int ADDR_W    = 7;
  localparam int DATA_W    = 9;
  localparam int REG_COUNT = 8;

  // register indices into the bank
  localparam int IDX_NOISE_GATE = 0;
  localparam int IDX_PLL_INT    = 1;
  localparam int IDX_FRAC_HIGH  = 2;
  localparam int IDX_FRAC_MID   = 3;
  localparam int IDX_FRAC_LOW   = 4;
  localparam int IDX_OUT_ATTEN  = 5;
  localparam int IDX_IN_ROUTING = 6;
  localparam int IDX_AMP_GAIN   = 7;

  localparam logic [6:0] ADDR_NOISE_GATE = 7'h23;
  localparam logic [6:0] ADDR_PLL_INT    = 7'h24;
  localparam logic [6:0] ADDR_FRAC_HIGH  = 7'h25;
  localparam logic [6:0] ADDR_FRAC_MID   = 7'h26;
  localparam logic [6:0] ADDR_FRAC_LOW   = 7'h27;
  localparam logic [6:0] ADDR_OUT_ATTEN  = 7'h28;
  localparam logic [6:0] ADDR_IN_ROUTING = 7'h2C;
  localparam logic [6:0] ADDR_AMP_GAIN   = 7'h2D;

  localparam logic [6:0] REG_ADDR [REG_COUNT] = '{
    ADDR_NOISE_GATE, ADDR_PLL_INT, ADDR_FRAC_HIGH, ADDR_FRAC_MID,
    ADDR_FRAC_LOW, ADDR_OUT_ATTEN, ADDR_IN_ROUTING, ADDR_AMP_GAIN};

  localparam logic [8:0] REG_RESET [REG_COUNT] = '{
    9'h000, 9'h008, 9'h00C, 9'h093, 9'h0E9, 9'h000, 9'h003, 9'h010};

  // writable bits; the rest are fixed zero
  localparam logic [8:0] REG_MASK [REG_COUNT] = '{
    9'h00F, 9'h01F, 9'h03F, 9'h1FF, 9'h1FF, 9'h007, 9'h18F, 9'h0FF};

  // field positions
  localparam int NG_EN_BIT       = 3;
  localparam int PLL_PRESC_BIT   = 4;
  localparam int ATT_MONO_BIT    = 2;
  localparam int ATT_SPK_BIT     = 1;
  localparam int BIAS_MODE_BIT   = 0;
  localparam int RT_MIC_EN_BIT   = 8;
  localparam int RT_BIAS_VOLTAGE_SELECT_LSB    = 7;
  localparam int RT_AUX_MODE_BIT = 3;
  localparam int RT_AUX_AMP_BIT  = 2;
  localparam int RT_NEG_MIC_BIT  = 1;
  localparam int RT_POS_SRC_BIT  = 0;
  localparam int GAIN_ZC_BIT     = 7;
  localparam int GAIN_MUTE_BIT   = 6;

  // valid integer pll ratio range
  localparam logic [3:0] PLL_INT_MIN = 4'h5;
  localparam logic [3:0] PLL_INT_MAX = 4'hD;

  // threshold in dB below full scale: base plus step per code
  localparam logic [7:0] NG_THR_BASE_DB = 8'h27;
  localparam logic [7:0] NG_THR_STEP_DB = 8'h06;

  // amplifier gain in quarter dB: code times step minus offset
  localparam logic [8:0] GAIN_STEP_QDB   = 9'h003;
  localparam logic [8:0] GAIN_OFFSET_QDB = 9'h030;

  // microphone bias ratio of the analog supply
  typedef enum logic [2:0] {
    CIPR_BIAS_090 = 3'h0,
    CIPR_BIAS_085 = 3'h1,
    CIPR_BIAS_075 = 3'h2,
    CIPR_BIAS_070 = 3'h3,
    CIPR_BIAS_065 = 3'h4,
    CIPR_BIAS_060 = 3'h5,
    CIPR_BIAS_050 = 3'h6
  } cipr_bias_e;

endpackage

// [src/cipr_sync2.sv]
// two-flop synchroniser for one asynchronous level
// assumes the input is slow against core_clk
`timescale 1ns/1ns
module cipr_sync2
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // level
  input  wire logic d,
  output logic      q
);

  logic meta_q;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      meta_q <= 1'b0;
      q      <= 1'b0;
    end
    else
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

// [src/cipr_reg9.sv]
// one 9-bit configuration register with reset value and write mask
// assumes a one-cycle write enable from the same clock
`timescale 1ns/1ns
module cipr_reg9
#(
  parameter logic [8:0] RESET_VAL = 9'h000,
  parameter logic [8:0] WR_MASK   = 9'h1FF
)
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // write side
  input  wire logic       wr_en,
  input  wire logic [8:0] wdata,
  output logic      [8:0] q
);

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      q <= RESET_VAL;
    else if (wr_en)
      q <= wdata & WR_MASK;
  end

endmodule

// [src/cipr_regs.sv]
// configuration registers noise_gate_control to input_amp_gain_control: noise gate, pll, attenuation,
// input routing, bias and input amplifier gain with zero-cross update
// assumes a same-clock register port and an async comparator sign input
`timescale 1ns/1ns
module cipr_regs
  import cipr_pkg::*;
(
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // register port
  input  wire logic [6:0]       reg_addr,
  input  wire logic [8:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [8:0]       reg_rdata,
  // comparator sign of the amplifier input, asynchronous
  input  wire logic             amp_sign_in,
  // noise gate
  output logic                  noise_gate_enable,
  output logic      [2:0]       noise_gate_threshold,
  output logic      [7:0]       noise_gate_thr_db,
  // pll
  output logic      [3:0]       pll_integer_ratio,
  output logic                  pll_int_valid,
  output logic                  pll_input_prescale,
  output logic      [23:0]      pll_fraction_ratio,
  // output attenuation and bias
  output logic                  mono_out_attenuate,
  output logic                  speaker_path_attenuate,
  output logic                  bias_mode_select,
  output logic      [1:0]       bias_voltage_select,
  output cipr_bias_e            bias_ratio,
  // input routing
  output logic                  mic_input_enable,
  output logic                  aux_input_mode,
  output logic                  aux_to_input_amp,
  output logic                  neg_mic_to_input_amp,
  output logic                  pos_terminal_source,
  // input amplifier
  output logic      [5:0]       input_amp_gain,
  output logic      [8:0]       input_amp_gain_qdb,
  output logic                  input_amp_zero_cross_update,
  output logic                  input_amp_mute
);

  logic [8:0]  reg_q [REG_COUNT];
  logic [8:0]  rd_mux;
  logic        rd_hit;
  logic        sign_s;
  logic        sign_prev_q;
  logic        zc_evt;
  logic        gain_wr;
  logic        gain_pend_q;
  logic [5:0]  gain_apply_q;
  logic [5:0]  gain_apply_d;
  logic [8:0]  gain_qdb_q;
  logic [7:0]  thr_db_q;
  logic        pll_valid_q;
  cipr_bias_e  bias_q;
  cipr_bias_e  bias_d;
  logic [8:0]  rdata_q;

  // register bank
  genvar gi;
  generate
    for (gi = 0; gi < REG_COUNT; gi++)
    begin : g_reg
      cipr_reg9
      #(
        .RESET_VAL (REG_RESET[gi]),
        .WR_MASK   (REG_MASK[gi])
      )
      u_reg
      (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .wr_en    (reg_wr && (reg_addr == REG_ADDR[gi])),
        .wdata    (reg_wdata),
        .q        (reg_q[gi])
      );
    end
  endgenerate

  // read mux; unmapped addresses read zero
  always_comb
  begin
    rd_mux = 9'h000;
    rd_hit = 1'b0;
    for (int i = 0; i < REG_COUNT; i++)
    begin
      if (reg_addr == REG_ADDR[i])
      begin
        rd_mux = reg_q[i];
        rd_hit = 1'b1;
      end
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      rdata_q <= 9'h000;
    else if (reg_rd && rd_hit)
      rdata_q <= rd_mux;
    else
      rdata_q <= 9'h000;
  end

  assign reg_rdata = rdata_q;

  // noise gate fields and threshold depth
  assign noise_gate_enable    = reg_q[IDX_NOISE_GATE][NG_EN_BIT];
  assign noise_gate_threshold = reg_q[IDX_NOISE_GATE][2:0];

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      thr_db_q <= NG_THR_BASE_DB;
    else
      thr_db_q <= NG_THR_BASE_DB
                + 8'({5'h00, reg_q[IDX_NOISE_GATE][2:0]} * NG_THR_STEP_DB);
  end

  assign noise_gate_thr_db = thr_db_q;

  // pll; invalid integer codes are passed on but flagged
  assign pll_integer_ratio  = reg_q[IDX_PLL_INT][3:0];
  assign pll_input_prescale = reg_q[IDX_PLL_INT][PLL_PRESC_BIT];
  assign pll_fraction_ratio = {reg_q[IDX_FRAC_HIGH][5:0],
                               reg_q[IDX_FRAC_MID],
                               reg_q[IDX_FRAC_LOW]};

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      pll_valid_q <= 1'b1;
    else
      pll_valid_q <= (reg_q[IDX_PLL_INT][3:0] >= PLL_INT_MIN)
                  && (reg_q[IDX_PLL_INT][3:0] <= PLL_INT_MAX);
  end

  assign pll_int_valid = pll_valid_q;

  // attenuation and bias mode
  assign mono_out_attenuate     = reg_q[IDX_OUT_ATTEN][ATT_MONO_BIT];
  assign speaker_path_attenuate = reg_q[IDX_OUT_ATTEN][ATT_SPK_BIT];
  assign bias_mode_select       = reg_q[IDX_OUT_ATTEN][BIAS_MODE_BIT];
  assign bias_voltage_select    = reg_q[IDX_IN_ROUTING][RT_BIAS_VOLTAGE_SELECT_LSB+1:RT_BIAS_VOLTAGE_SELECT_LSB];

  // bias ratio decode; code 3 is half supply in both modes
  always_comb
  begin
    case (reg_q[IDX_IN_ROUTING][RT_BIAS_VOLTAGE_SELECT_LSB+1:RT_BIAS_VOLTAGE_SELECT_LSB])
      2'h0:    bias_d = bias_mode_select ? CIPR_BIAS_085 : CIPR_BIAS_090;
      2'h1:    bias_d = bias_mode_select ? CIPR_BIAS_060 : CIPR_BIAS_065;
      2'h2:    bias_d = bias_mode_select ? CIPR_BIAS_070 : CIPR_BIAS_075;
      2'h3:    bias_d = CIPR_BIAS_050;
      default: bias_d = CIPR_BIAS_050;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      bias_q <= CIPR_BIAS_090;
    else
      bias_q <= bias_d;
  end

  assign bias_ratio = bias_q;

  // input routing
  assign mic_input_enable     = reg_q[IDX_IN_ROUTING][RT_MIC_EN_BIT];
  assign aux_input_mode       = reg_q[IDX_IN_ROUTING][RT_AUX_MODE_BIT];
  assign aux_to_input_amp     = reg_q[IDX_IN_ROUTING][RT_AUX_AMP_BIT];
  assign neg_mic_to_input_amp = reg_q[IDX_IN_ROUTING][RT_NEG_MIC_BIT];
  assign pos_terminal_source  = reg_q[IDX_IN_ROUTING][RT_POS_SRC_BIT];

  // input amplifier control bits
  assign input_amp_zero_cross_update = reg_q[IDX_AMP_GAIN][GAIN_ZC_BIT];
  assign input_amp_mute              = reg_q[IDX_AMP_GAIN][GAIN_MUTE_BIT];

  // zero crossing: any change of the synchronised sign
  cipr_sync2 u_sign_sync
  (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .d        (amp_sign_in),
    .q        (sign_s)
  );

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      sign_prev_q <= 1'b0;
    else
      sign_prev_q <= sign_s;
  end

  assign zc_evt  = sign_s ^ sign_prev_q;
  assign gain_wr = reg_wr && (reg_addr == ADDR_AMP_GAIN);

  // a crossing in the write cycle does not count; a write beats the clear
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      gain_pend_q <= 1'b0;
    else if (gain_wr && reg_wdata[GAIN_ZC_BIT])
      gain_pend_q <= 1'b1;
    else if (zc_evt || !input_amp_zero_cross_update)
      gain_pend_q <= 1'b0;
  end

  always_comb
  begin
    if (!input_amp_zero_cross_update)
      gain_apply_d = reg_q[IDX_AMP_GAIN][5:0];
    else if (gain_pend_q && zc_evt)
      gain_apply_d = reg_q[IDX_AMP_GAIN][5:0];
    else
      gain_apply_d = gain_apply_q;
  end

  // quarter-dB view moves with the applied code, no extra lag
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      gain_apply_q <= REG_RESET[IDX_AMP_GAIN][5:0];
      gain_qdb_q   <= 9'h000;
    end
    else
    begin
      gain_apply_q <= gain_apply_d;
      gain_qdb_q   <= 9'({3'h0, gain_apply_d} * GAIN_STEP_QDB)
                    - GAIN_OFFSET_QDB;
    end
  end

  assign input_amp_gain     = gain_apply_q;
  assign input_amp_gain_qdb = gain_qdb_q;

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_gain_wr_now;
    gain_wr && !reg_wdata[GAIN_ZC_BIT];
  endsequence

  sequence s_gain_wait;
    gain_pend_q && input_amp_zero_cross_update && !zc_evt;
  endsequence

  a_thr_depth_map: assert property (
    ##1 thr_db_q == 8'h27 + 8'({5'h00, $past(noise_gate_threshold)} * 8'h06))
    else $error("noise gate threshold depth wrong");

  a_pll_int_valid: assert property (
    ##1 pll_valid_q == ($past(pll_integer_ratio) >= 4'h5
                     && $past(pll_integer_ratio) <= 4'hD))
    else $error("pll ratio valid flag wrong");

  a_pll_prescale_wr: assert property (
    reg_wr && reg_addr == ADDR_PLL_INT |=> pll_input_prescale == $past(reg_wdata[4]))
    else $error("pll prescale bit not written");

  a_frac_assembly: assert property (
    reg_wr && reg_addr == ADDR_FRAC_HIGH
    |=> pll_fraction_ratio[23:18] == $past(reg_wdata[5:0]))
    else $error("pll fraction high bits wrong");

  a_atten_bits: assert property (
    reg_wr && reg_addr == ADDR_OUT_ATTEN
    |=> {mono_out_attenuate, speaker_path_attenuate} == $past(reg_wdata[2:1]))
    else $error("attenuation bits wrong");

  a_atten_reserved: assert property (
    reg_q[IDX_OUT_ATTEN][8:3] == 6'h00)
    else $error("attenuation reserved bits set");

  a_bias_half_supply: assert property (
    bias_voltage_select == 2'h3 |=> bias_ratio == CIPR_BIAS_050)
    else $error("bias code 3 not half supply");

  a_bias_mode_pick: assert property (
    bias_voltage_select == 2'h0 && bias_mode_select |=> bias_ratio == CIPR_BIAS_085)
    else $error("bias mode ratio wrong");

  a_route_bits: assert property (
    reg_wr && reg_addr == ADDR_IN_ROUTING
    |=> {aux_input_mode, aux_to_input_amp, neg_mic_to_input_amp,
         pos_terminal_source} == $past(reg_wdata[3:0]))
    else $error("routing bits wrong");

  a_gain_qdb_map: assert property (
    input_amp_gain == 6'h10 |-> input_amp_gain_qdb == 9'h000)
    else $error("gain code 16 not 0 dB");

  a_gain_now: assert property (
    s_gain_wr_now |-> ##2 input_amp_gain == $past(reg_wdata[5:0], 2))
    else $error("immediate gain not applied");

  a_gain_hold: assert property (
    s_gain_wait |=> $stable(input_amp_gain))
    else $error("deferred gain moved early");

  a_gain_at_cross: assert property (
    gain_pend_q && input_amp_zero_cross_update && zc_evt
    |=> input_amp_gain == $past(reg_q[IDX_AMP_GAIN][5:0]))
    else $error("gain not applied at crossing");

  a_mute_write: assert property (
    gain_wr |=> input_amp_mute == $past(reg_wdata[6]))
    else $error("mute bit not written");

  a_unmapped_read: assert property (
    reg_rd && !rd_hit |=> reg_rdata == 9'h000)
    else $error("unmapped read not zero");

  a_read_back: assert property (
    reg_rd && reg_addr == ADDR_IN_ROUTING |=> reg_rdata[6:4] == 3'h0)
    else $error("routing reserved bits read nonzero");

endmodule

// [tb/cipr_host.sv]
// host model: drives the register port of the configuration slice
// assumes one clock; strobes launch just after a rising edge
`timescale 1ns/1ns
module cipr_host
(
  // clock
  input  wire logic       core_clk,
  // register port
  output logic      [6:0] reg_addr,
  output logic      [8:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [8:0] reg_rdata
);
  initial
  begin
    reg_addr  = 7'h00;
    reg_wdata = 9'h000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // one-cycle strobe; data inverted after release so stale data never matches
  task automatic wr(input logic [6:0] a, input logic [8:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [6:0] a, output logic [8:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask
endmodule

// [tb/test_cipr_regs.sv]
// self-checking bench for the configuration register slice
// assumes cipr_host drives the register port; this module drives the rest
`timescale 1ns/1ns
module test_cipr_regs;
  logic        core_clk    = 1'b0;
  logic        rst_n       = 1'b0;
  logic        amp_sign_in = 1'b0;
  logic [6:0]  reg_addr;
  logic [8:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [8:0]  reg_rdata;
  logic        noise_gate_enable;
  logic [2:0]  noise_gate_threshold;
  logic [7:0]  noise_gate_thr_db;
  logic [3:0]  pll_integer_ratio;
  logic        pll_int_valid;
  logic        pll_input_prescale;
  logic [23:0] pll_fraction_ratio;
  logic        mono_out_attenuate;
  logic        speaker_path_attenuate;
  logic        bias_mode_select;
  logic [1:0]  bias_voltage_select;
  logic [2:0]  bias_ratio;
  logic        mic_input_enable;
  logic        aux_input_mode;
  logic        aux_to_input_amp;
  logic        neg_mic_to_input_amp;
  logic        pos_terminal_source;
  logic [5:0]  input_amp_gain;
  logic [8:0]  input_amp_gain_qdb;
  logic        input_amp_zero_cross_update;
  logic        input_amp_mute;
  int          err_total  = 0;
  int          num_checks = 0;
  int          seed       = 5923;
  int          mdl [8];
  int          app_gain;
  int          k;
  int          t;
  logic [8:0]  d;
  logic [8:0]  rv;
  logic [6:0]  adr [8] = '{7'h23, 7'h24, 7'h25, 7'h26, 7'h27, 7'h28, 7'h2C, 7'h2D};
  logic [8:0]  rst [8] = '{9'h000, 9'h008, 9'h00C, 9'h093, 9'h0E9, 9'h000, 9'h003, 9'h010};
  logic [8:0]  msk [8] = '{9'h00F, 9'h01F, 9'h03F, 9'h1FF, 9'h1FF, 9'h007, 9'h18F, 9'h0FF};

  always #10 core_clk = ~core_clk;

  cipr_host host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  cipr_regs dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .amp_sign_in(amp_sign_in), .noise_gate_enable(noise_gate_enable),
    .noise_gate_threshold(noise_gate_threshold), .noise_gate_thr_db(noise_gate_thr_db),
    .pll_integer_ratio(pll_integer_ratio), .pll_int_valid(pll_int_valid),
    .pll_input_prescale(pll_input_prescale), .pll_fraction_ratio(pll_fraction_ratio),
    .mono_out_attenuate(mono_out_attenuate), .speaker_path_attenuate(speaker_path_attenuate),
    .bias_mode_select(bias_mode_select), .bias_voltage_select(bias_voltage_select),
    .bias_ratio(bias_ratio), .mic_input_enable(mic_input_enable),
    .aux_input_mode(aux_input_mode), .aux_to_input_amp(aux_to_input_amp),
    .neg_mic_to_input_amp(neg_mic_to_input_amp), .pos_terminal_source(pos_terminal_source),
    .input_amp_gain(input_amp_gain), .input_amp_gain_qdb(input_amp_gain_qdb),
    .input_amp_zero_cross_update(input_amp_zero_cross_update),
    .input_amp_mute(input_amp_mute));

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %s expected %0h seen %0h", n, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // enum order: 0.90 0.85 0.75 0.70 0.65 0.60 0.50
  function automatic int bias_exp(input int c, input int m);
    return c == 3 ? 6 : (c == 0 ? 0 : (c == 1 ? 4 : 2)) + m;
  endfunction

  task automatic do_reset(input int n);
    rst_n <= 1'b0;
    repeat (n) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++)
      mdl[i] = rst[i];
    app_gain = 16;
  endtask

  // model tracks only stored bits; gain follows unless zero-cross deferral is on
  task automatic w(input int i, input logic [8:0] v);
    host.wr(adr[i], v);
    mdl[i] = v & msk[i];
    if (i == 7 && !v[7])
      app_gain = v[5:0];
  endtask

  task automatic read_all();
    for (int i = 0; i < 8; i++)
    begin
      host.rd(adr[i], rv);
      chk("rdata", rv, mdl[i]);
    end
    host.rd(7'h29, rv);
    chk("unmapped", rv, 0);
    @(posedge core_clk);
    #1 chk("rdata_idle", reg_rdata, 0);
  endtask

  task automatic check_fields();
    @(posedge core_clk);
    #1;
    chk("gate", {noise_gate_enable, noise_gate_threshold}, mdl[0][3:0]);
    chk("thr_db", noise_gate_thr_db, 39 + 6 * mdl[0][2:0]);
    chk("pll_int", {pll_input_prescale, pll_integer_ratio}, mdl[1][4:0]);
    chk("pll_ok", pll_int_valid, mdl[1][3:0] >= 5 && mdl[1][3:0] <= 13);
    chk("frac", pll_fraction_ratio, {mdl[2][5:0], mdl[3][8:0], mdl[4][8:0]});
    chk("atten", {mono_out_attenuate, speaker_path_attenuate}, mdl[5][2:1]);
    chk("bias_mode", bias_mode_select, mdl[5][0]);
    chk("bias_v", bias_voltage_select, mdl[6][8:7]);
    chk("mic_en", mic_input_enable, mdl[6][8]);
    chk("bias", bias_ratio, bias_exp(mdl[6][8:7], mdl[5][0]));
    chk("aux", {aux_input_mode, aux_to_input_amp}, mdl[6][3:2]);
    chk("mic", {neg_mic_to_input_amp, pos_terminal_source}, mdl[6][1:0]);
    chk("amp", {input_amp_zero_cross_update, input_amp_mute}, mdl[7][7:6]);
    chk("gain", input_amp_gain, app_gain[5:0]);
    chk("gain_qdb", input_amp_gain_qdb, (app_gain * 3 - 48) & 9'h1FF);
  endtask

  initial
  begin
    do_reset(16);
    read_all();
    check_fields();
    $display("test reset done");
    // every pll code, threshold and bias pairing, invalid pll codes on purpose
    for (int i = 0; i < 16; i++)
    begin
      w(1, 9'(i));
      w(0, 9'(i));
      w(5, 9'(i));
      w(6, 9'(i << 5));
      check_fields();
    end
    $display("test sweep done");
    for (int n = 0; n < 60; n++)
    begin
      k = $unsigned($random(seed)) % 8;
      d = 9'($random(seed));
      if (k == 1)
        d[3:0] = 4'(5 + d % 9);
      w(k, d);
      host.wr(7'h2A, ~d);
      check_fields();
    end
    read_all();
    $display("test random done");
    // known gain first, so the deferred code always differs from the applied one
    w(7, 9'h010);
    w(7, 9'h0A0);
    repeat (6) @(posedge core_clk);
    #1 chk("zc_hold", input_amp_gain, app_gain[5:0]);
    @(posedge core_clk);
    amp_sign_in <= ~amp_sign_in;
    // look 1 ns after each edge so the gain flop has settled
    for (t = 0; t < 10 && input_amp_gain !== 6'h20; t++)
    begin
      @(posedge core_clk);
      #1;
    end
    app_gain = 32;
    chk("zc_apply", t < 10, 1);
    chk("zc_latency", t, 3);
    if (t == 10)
      report_and_stop();
    check_fields();
    w(7, 9'h06A);
    check_fields();
    $display("test zero cross done");
    do_reset(2);
    read_all();
    check_fields();
    $display("test second reset done");
    report_and_stop();
  end
endmodule
